// [src/pss_port.sv]
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - a direction bit of one makes its pin an output, zero an input.
// - an enabled sync serial unit sets direction of pins 7-4, bits kept.
// - an enabled second async unit sets direction of pins 3-2, bits kept.
// - an enabled first async unit sets direction of pins 1-0, bits kept.
// - direction, pull enable and open-drain registers are always rw.
// - a reduced drive bit of one selects about 1/5 drive, zero full drive.
// - reduced drive applies to port or peripheral output, never to input.
// - a pull enable bit of one turns the pin's pull device on.
// - on an output the pull enable only acts in open-drain mode.
// - a polarity bit of one picks pull-down, zero pull-up, when enabled.
// - in open-drain mode zero drives low and one leaves the pin undriven.
// - open-drain applies whatever drives the pin and never to inputs.
// - an enabled peripheral takes precedence over port use of its pins.
module pss_port
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_b,
  // wishbone slave
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [7:0]           i_wb_adr,
  input  wire logic [3:0]           i_wb_sel,
  input  wire logic [31:0]          i_wb_dat,
  output logic      [31:0]          o_wb_dat,
  output logic                      o_wb_ack,
  // port output data from the data register
  input  wire logic [WIDTH-1:0]     i_port_out,
  // peripheral claims
  input  wire pss_pkg::pss_periph_t i_sync_ser,
  input  wire pss_pkg::pss_periph_t i_async_second,
  input  wire pss_pkg::pss_periph_t i_async_first,
  // pad controls
  output logic      [WIDTH-1:0]     o_out_en_b,
  output pss_pkg::pss_pad_t [WIDTH-1:0] o_pad
);
  import pss_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // registers and wires

  logic [WIDTH-1:0]  pin_direction_bits_r;
  logic [WIDTH-1:0]  reduced_drive_bits_r;
  logic [WIDTH-1:0]  pull_enable_bits_r;
  logic [WIDTH-1:0]  pull_polarity_bits_r;
  logic [WIDTH-1:0]  open_drain_bits_r;
  logic [31:0]       rd_data_nxt;
  logic              ack_r;
  logic              req;
  logic              wr_stb;
  logic [WIDTH-1:0]  eff_dir;
  pss_periph_t [WIDTH-1:0] claim;
  pss_pad_t    [WIDTH-1:0] pad_w;
  logic        [WIDTH-1:0] oe_b_w;

  //////////////////////////////////////////////////////////////////////////
  // bus handshake: ack one cycle after request, dropped the next cycle

  assign req    = i_wb_cyc & i_wb_stb;
  assign wr_stb = req & i_wb_we & ~ack_r & i_wb_sel[0];

  // ack generation
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  assign o_wb_ack = ack_r;

  //////////////////////////////////////////////////////////////////////////
  // configuration registers, writable at any time

  // direction register, never touched by peripherals
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      pin_direction_bits_r <= PSS_RST_CFG;
    else if (wr_stb && i_wb_adr == PSS_OFS_DIRECTION)
      pin_direction_bits_r <= i_wb_dat[WIDTH-1:0];
  end

  // reduced drive register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      reduced_drive_bits_r <= PSS_RST_CFG;
    else if (wr_stb && i_wb_adr == PSS_OFS_DRIVE)
      reduced_drive_bits_r <= i_wb_dat[WIDTH-1:0];
  end

  // pull enable register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      pull_enable_bits_r <= PSS_RST_CFG;
    else if (wr_stb && i_wb_adr == PSS_OFS_PULL_EN)
      pull_enable_bits_r <= i_wb_dat[WIDTH-1:0];
  end

  // pull polarity register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      pull_polarity_bits_r <= PSS_RST_CFG;
    else if (wr_stb && i_wb_adr == PSS_OFS_PULL_POL)
      pull_polarity_bits_r <= i_wb_dat[WIDTH-1:0];
  end

  // open-drain register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      open_drain_bits_r <= PSS_RST_CFG;
    else if (wr_stb && i_wb_adr == PSS_OFS_OPEN_DRN)
      open_drain_bits_r <= i_wb_dat[WIDTH-1:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux, unmapped addresses read zero

  always_comb
  begin
    rd_data_nxt = 32'h0000_0000;
    unique case (i_wb_adr)
      PSS_OFS_DIRECTION: rd_data_nxt[WIDTH-1:0] = pin_direction_bits_r;
      PSS_OFS_DRIVE:     rd_data_nxt[WIDTH-1:0] = reduced_drive_bits_r;
      PSS_OFS_PULL_EN:   rd_data_nxt[WIDTH-1:0] = pull_enable_bits_r;
      PSS_OFS_PULL_POL:  rd_data_nxt[WIDTH-1:0] = pull_polarity_bits_r;
      PSS_OFS_OPEN_DRN:  rd_data_nxt[WIDTH-1:0] = open_drain_bits_r;
      PSS_OFS_STATUS:    rd_data_nxt[WIDTH-1:0] = eff_dir;
      default:           rd_data_nxt = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      o_wb_dat <= 32'h0000_0000;
    else if (req && !ack_r)
      o_wb_dat <= rd_data_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // peripheral claims per pin

  generate
    for (genvar g = 0; g < WIDTH; g++)
    begin : g_claim
      if (g >= PSS_SYNC_LO)
      begin : g_sync
        assign claim[g] = i_sync_ser;
      end
      else if (g >= PSS_ASYNC2_LO)
      begin : g_async2
        assign claim[g] = i_async_second;
      end
      else
      begin : g_async1
        assign claim[g] = i_async_first;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // pin cells

  generate
    for (genvar p = 0; p < WIDTH; p++)
    begin : g_pin
      pss_pin_cell u_cell
      (
        .i_dir        (pin_direction_bits_r[p]),
        .i_port_out   (i_port_out[p]),
        .i_periph     (claim[p]),
        .i_reduced    (reduced_drive_bits_r[p]),
        .i_pull_en    (pull_enable_bits_r[p]),
        .i_pull_pol   (pull_polarity_bits_r[p]),
        .i_open_drain (open_drain_bits_r[p]),
        .o_out_en_b   (oe_b_w[p]),
        .o_pad        (pad_w[p]),
        .o_eff_dir    (eff_dir[p])
      );
    end
  endgenerate

  assign o_pad      = pad_w;
  assign o_out_en_b = oe_b_w;

  //////////////////////////////////////////////////////////////////////////
  // checks

  // ack is a single-cycle pulse
  AST_ACK_ONE: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  // ack follows a taken request by one cycle
  AST_ACK_DELAY: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (req && !ack_r) |=> o_wb_ack)
    else $error("ack not given one cycle after request");

  // ack never comes without a request taken the cycle before
  AST_ACK_REQ: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_wb_ack |-> $past(req && !ack_r))
    else $error("ack given without a request");

  // upper read lanes stay zero
  AST_RD_UPPER: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_wb_ack |-> o_wb_dat[31:WIDTH] == '0)
    else $error("read data upper bits not zero");

  // direction read returns the stored bits
  AST_RD_BACK: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (req && !ack_r && !i_wb_we && i_wb_adr == PSS_OFS_DIRECTION) |=>
      o_wb_dat[WIDTH-1:0] == $past(pin_direction_bits_r))
    else $error("direction read does not return stored bits");

  // open-drain write lands whatever the pin state
  AST_WRITE_ANY: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (wr_stb && i_wb_adr == PSS_OFS_OPEN_DRN) |=>
      open_drain_bits_r == $past(i_wb_dat[WIDTH-1:0]))
    else $error("open-drain write not taken");

  // pull enable write lands whatever the pin state
  AST_WRITE_PULL: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (wr_stb && i_wb_adr == PSS_OFS_PULL_EN) |=>
      pull_enable_bits_r == $past(i_wb_dat[WIDTH-1:0]))
    else $error("pull enable write not taken");

  // sync serial unit owns the direction of pins 7-4
  AST_DIR_FORCE: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_sync_ser.enable |-> eff_dir[7:4] == {4{i_sync_ser.dir}})
    else $error("sync serial unit does not set pins 7-4 direction");

  // second async unit owns the direction of pins 3-2
  AST_DIR_SECOND: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_async_second.enable |-> eff_dir[3:2] == {2{i_async_second.dir}})
    else $error("second async unit does not set pins 3-2 direction");

  // first async unit owns the direction of pins 1-0
  AST_DIR_FIRST: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_async_first.enable |-> eff_dir[1:0] == {2{i_async_first.dir}})
    else $error("first async unit does not set pins 1-0 direction");

  // a claiming peripheral leaves the stored bits alone
  AST_DIR_KEEP: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_async_second.enable && !wr_stb) |=>
      $stable(pin_direction_bits_r))
    else $error("direction bits changed by peripheral");

  // stored bits still take writes while the pins are claimed
  AST_DIR_STORE: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_sync_ser.enable && wr_stb && i_wb_adr == PSS_OFS_DIRECTION) |=>
      pin_direction_bits_r == $past(i_wb_dat[WIDTH-1:0]))
    else $error("direction write lost while pins claimed");

  // unclaimed low pin follows its direction bit
  AST_DIR_PORT: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !i_async_first.enable |-> eff_dir[0] == pin_direction_bits_r[0])
    else $error("direction bit not obeyed on pin 0");

  // unclaimed top pin follows its direction bit
  AST_DIR_TOP: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !i_sync_ser.enable |-> eff_dir[7] == pin_direction_bits_r[7])
    else $error("direction bit not obeyed on pin 7");

  // open-drain one releases the pin
  AST_OD_HIGH: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (eff_dir[3] && open_drain_bits_r[3] && claim[3].enable && claim[3].out)
      |-> o_out_en_b[3])
    else $error("open-drain one drives the pin");

  // open-drain zero pulls the pin low
  AST_OD_LOW: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (eff_dir[0] && open_drain_bits_r[0] &&
      !(claim[0].enable ? claim[0].out : i_port_out[0]))
      |-> (!o_out_en_b[0] && !o_pad[0].level))
    else $error("open-drain zero not driven low");

  // push-pull output drives its value
  AST_PUSH_PULL: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (eff_dir[1] && !open_drain_bits_r[1]) |-> (!o_out_en_b[1] &&
      o_pad[1].level == (claim[1].enable ? claim[1].out : i_port_out[1])))
    else $error("push-pull output not driven with its value");

  // claiming peripheral value wins over the port data
  AST_PERIPH_WINS: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_async_first.enable && i_async_first.dir && !open_drain_bits_r[1])
      |-> o_pad[1].level == i_async_first.out)
    else $error("peripheral value not on its pin");

  // open-drain bit has no effect on an input
  AST_OD_INPUT: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !eff_dir[3] |-> (o_out_en_b[3] && !o_pad[3].level))
    else $error("open-drain bit acts on an input");

  // input is never driven nor reduced
  AST_IN_QUIET: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !eff_dir[5] |-> (o_out_en_b[5] && !o_pad[5].reduced))
    else $error("input pin driven or reduced");

  // output carries its reduced drive bit
  AST_REDUCED: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    eff_dir[4] |-> o_pad[4].reduced == reduced_drive_bits_r[4])
    else $error("reduced drive bit not applied on output");

  // push-pull output ignores the pull enable
  AST_PULL_OUT: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (eff_dir[6] && !open_drain_bits_r[6]) |-> !o_pad[6].pull_on)
    else $error("pull active on push-pull output");

  // input pull follows its enable bit
  AST_PULL_IN: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !eff_dir[2] |-> o_pad[2].pull_on == pull_enable_bits_r[2])
    else $error("input pull does not follow its enable");

  // pull-down only where the pull is on and polarity asks for it
  AST_PULL_POL: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_pad[7].pull_down == (o_pad[7].pull_on && pull_polarity_bits_r[7]))
    else $error("pull polarity not applied");

endmodule : pss_port

// [src/pss_pkg.sv]
package pss_pkg;

  // register word offsets (byte addresses on a 32-bit bus)
  localparam logic [7:0] PSS_OFS_DIRECTION = 8'h00;
  localparam logic [7:0] PSS_OFS_DRIVE     = 8'h04;
  localparam logic [7:0] PSS_OFS_PULL_EN   = 8'h08;
  localparam logic [7:0] PSS_OFS_PULL_POL  = 8'h0c;
  localparam logic [7:0] PSS_OFS_OPEN_DRN  = 8'h10;
  localparam logic [7:0] PSS_OFS_STATUS    = 8'h14;

  // values after reset
  localparam logic [7:0] PSS_RST_CFG       = 8'h00;

  // pin group positions
  localparam int PSS_SYNC_LO  = 4;
  localparam int PSS_ASYNC2_LO = 2;
  localparam int PSS_ASYNC1_LO = 0;

  // one pad's control bundle
  typedef struct packed {
    logic drive;     // pad output enable, high = driving
    logic level;     // level driven when drive is high
    logic reduced;   // reduced drive strength
    logic pull_on;   // pull device active
    logic pull_down; // pull polarity, high = down
  } pss_pad_t;

  // one peripheral's claim on a pin
  typedef struct packed {
    logic enable; // peripheral owns the pin
    logic dir;    // peripheral wants output
    logic out;    // peripheral output level
  } pss_periph_t;

endpackage : pss_pkg

// [src/pss_pin_cell.sv]
`timescale 1ns/1ps
module pss_pin_cell
(
  // port side
  input  wire logic                 i_dir,
  input  wire logic                 i_port_out,
  // peripheral side
  input  wire pss_pkg::pss_periph_t i_periph,
  // configuration
  input  wire logic                 i_reduced,
  input  wire logic                 i_pull_en,
  input  wire logic                 i_pull_pol,
  input  wire logic                 i_open_drain,
  // pad control
  output logic                      o_out_en_b,
  output pss_pkg::pss_pad_t         o_pad,
  output logic                      o_eff_dir
);
  import pss_pkg::*;

  logic eff_val;

  // pad control from direction, value and configuration
  always_comb
  begin
    o_eff_dir  = i_periph.enable ? i_periph.dir : i_dir;
    eff_val    = i_periph.enable ? i_periph.out : i_port_out;
    o_pad.level   = 1'b0;
    o_pad.drive   = 1'b0;
    o_pad.reduced = 1'b0;
    if (o_eff_dir)
    begin
      if (i_open_drain)
      begin
        o_pad.drive = ~eff_val;
        o_pad.level = 1'b0;
      end
      else
      begin
        o_pad.drive = 1'b1;
        o_pad.level = eff_val;
      end
      o_pad.reduced = i_reduced;
    end
    o_pad.pull_on   = i_pull_en & (~o_eff_dir | i_open_drain);
    o_pad.pull_down = o_pad.pull_on & i_pull_pol;
    o_out_en_b      = ~o_pad.drive;
  end

endmodule : pss_pin_cell

// [sim/tb_pss_port.sv]
`timescale 1ns/1ps
module tb_pss_port;
  import pss_pkg::*;
  logic           i_clock;
  logic           i_rst_b;
  logic           cyc, stb, we, ack;
  logic [7:0]     adr, pout;
  logic [3:0]     sel;
  logic [31:0]    wdat, rdat, lf, q;
  logic [7:0]     out_en_b;
  pss_pad_t [7:0] pad;
  pss_periph_t    sy, a2, a1;
  logic [7:0]     cfg [5];
  logic [7:0]     ofs [5];
  int             fail_count, checks;

  pss_port #(.WIDTH(8)) pss_port_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_port_out(pout),
    .i_sync_ser(sy), .i_async_second(a2), .i_async_first(a1),
    .o_out_en_b(out_en_b), .o_pad(pad));

  //////////////////////////////////////////////////////////////////////////
  // 25 mhz clock
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction : lfsr_next

  // expected pad bundle of one pin: drive, level, reduced, pull, down
  function automatic logic [4:0] exp_pad(input logic d, v, odb, rd, pe,
                                         pp);
    logic od;
    logic pu;
    od = odb & d;
    pu = pe & (~d | od);
    return {d & (od ? ~v : 1'b1), d & v & ~od, d & rd, pu, pu & pp};
  endfunction : exp_pad

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // single-bit results
  task automatic chk_bit(input string nm, input logic e, g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, d,
                    input logic [3:0] s);
    int n;
    @(posedge i_clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {lf[31:8], d};
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      fail_count++;
      conclude();
    end
  endtask : wb

  // expected pad controls per pin, then the effective direction word
  task automatic check_pads();
    logic [7:0]  ed;
    pss_periph_t p;
    logic        d, v;
    logic [4:0]  e;
    #1;
    for (int i = 0; i < 8; i++)
    begin
      p = (i >= 4) ? sy : (i >= 2) ? a2 : a1;
      d = p.enable ? p.dir : cfg[0][i];
      v = p.enable ? p.out : pout[i];
      e = exp_pad(d, v, cfg[4][i], cfg[1][i], cfg[2][i], cfg[3][i]);
      ed[i] = d;
      chk_bit("pad drive", e[4], pad[i].drive);
      chk_bit("pad level", e[3], pad[i].level);
      chk_bit("pad reduced", e[2], pad[i].reduced);
      chk_bit("pad pull_on", e[1], pad[i].pull_on);
      chk_bit("pad pull_down", e[0], pad[i].pull_down);
      chk_bit("out_en_b", ~e[4], out_en_b[i]);
    end
    wb(1'b0, PSS_OFS_STATUS, 8'h00, 4'hf);
    chk("status", {24'h0, ed}, q);
  endtask : check_pads

  //////////////////////////////////////////////////////////////////////////
  // reset, corner cases, then random configurations
  initial
  begin
    {cyc, stb, we, adr, sel, wdat, pout, sy, a2, a1} = '0;
    i_rst_b = 1'b0;
    fail_count = 0;
    checks = 0;
    lf = 32'h0001_0363;
    ofs = '{PSS_OFS_DIRECTION, PSS_OFS_DRIVE, PSS_OFS_PULL_EN,
            PSS_OFS_PULL_POL, PSS_OFS_OPEN_DRN};
    for (int k = 0; k < 5; k++)
      cfg[k] = PSS_RST_CFG;
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      wb(1'b0, ofs[k], 8'h00, 4'hf);
      chk("reset value", 32'h0, q);
    end
    // lane 0 clear must not store, unmapped place reads zero
    wb(1'b1, ofs[0], 8'hff, 4'he);
    wb(1'b0, ofs[0], 8'h00, 4'hf);
    chk("masked write", 32'h0, q);
    wb(1'b1, 8'h18, 8'h5a, 4'hf);
    wb(1'b0, 8'h18, 8'h00, 4'hf);
    chk("unmapped", 32'h0, q);
    check_pads();
    repeat (60)
    begin
      for (int k = 0; k < 5; k++)
      begin
        lf = lfsr_next(lf);
        cfg[k] = lf[7:0];
        wb(1'b1, ofs[k], cfg[k], 4'hf);
      end
      lf = lfsr_next(lf);
      @(posedge i_clock);
      pout <= lf[7:0];
      sy   <= lf[10:8];
      a2   <= lf[13:11];
      a1   <= lf[16:14];
      check_pads();
      for (int k = 0; k < 5; k++)
      begin
        wb(1'b0, ofs[k], 8'h00, 4'hf);
        chk("readback", {24'h0, cfg[k]}, q);
      end
    end
    // mid-run reset clears every configuration register
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      cfg[k] = PSS_RST_CFG;
      wb(1'b0, ofs[k], 8'h00, 4'hf);
      chk("reset again", 32'h0, q);
    end
    check_pads();
    conclude();
  end

endmodule : tb_pss_port
